//--- design/agc_config_regs.sv
// front-end global configuration register bank with an AXI4-Lite slave
//
// What this block does
// - Global cathode bit: clear gives 1.3 V like the anode, set gives 1.8 V.
// - Six-bit channel shutdown field: zero keeps all on, 0x38 stops channels 2-4.
// - Second slot integration uses four channels, or channel one when its bit is set.
// - First slot integration uses four channels, or channel one when its bit is set.
// - Sleep with override applies the sleep cathode code; anode follows cathode.
// - Second slot with override applies its cathode code; anode stays 1.3 V.
// - First slot with override applies its cathode code; anode stays 1.3 V.
// - Override clear uses the global cathode bit; set uses sleep and slot codes in those phases, and the global bit when none is active.
// - Second slot runs digital integration when its enable bit is set, else normal.
// - First slot runs digital integration when its enable bit is set, else normal.
// - Gap mode off: regions abut; on: gap is the active slot's fine offset in us.
// - Second slot uses a single sample pair when its bit is set, else double.
// - First slot uses a single sample pair when its bit is set, else double.
`timescale 1ns/1ps
`default_nettype none
`include "agc_defines.svh"

module agc_config_regs (
  input  wire logic                   REF_CLK,
  input  wire logic                   NRST,
  input  wire logic                   CE,
  input  wire logic                   AWVALID,
  output var  logic                   AWREADY,
  input  wire logic [`AGC_ADDR_W-1:0] AWADDR,
  input  wire logic                   WVALID,
  output var  logic                   WREADY,
  input  wire logic [31:0]            WDATA,
  input  wire logic [3:0]             WSTRB,
  output var  logic                   BVALID,
  input  wire logic                   BREADY,
  output var  logic [1:0]             BRESP,
  input  wire logic                   ARVALID,
  output var  logic                   ARREADY,
  input  wire logic [`AGC_ADDR_W-1:0] ARADDR,
  output var  logic                   RVALID,
  input  wire logic                   RREADY,
  output var  logic [31:0]            RDATA,
  output var  logic [1:0]             RRESP,
  input  wire logic                   SLEEP_ACTIVE,
  input  wire logic                   SLOT_A_ACTIVE,
  input  wire logic                   SLOT_B_ACTIVE,
  input  wire logic [4:0]             FIRST_SLOT_FINE_OFFSET,
  input  wire logic [4:0]             SECOND_SLOT_FINE_OFFSET,
  output var  agc_pkg::agc_volt_type  CATHODE_LEVEL,
  output var  agc_pkg::agc_volt_type  ANODE_LEVEL,
  output var  logic [5:0]             FRONT_END_CHANNEL_SHUTDOWN,
  output var  logic [3:0]             ACTIVE_CHANNELS,
  output var  logic                   INTEG_ENABLE,
  output var  logic                   SINGLE_PAIR,
  output var  logic [4:0]             GAP_US
);
  import agc_pkg::*;

  localparam agc_state_type RESET_STATE = '{
    afe_bias_and_power:               `AGC_RST_BIAS,
    cathode_override_and_channel_use: `AGC_RST_OVR,
    slot_integration_enable:          `AGC_RST_INTEG,
    integration_sampling_options:     `AGC_RST_OPTS,
    aw_held:                          1'b0,
    aw_addr:                          '0,
    w_held:                           1'b0,
    w_data:                           '0,
    w_strb:                           '0,
    b_valid:                          1'b0,
    b_resp:                           `AGC_RESP_OKAY,
    r_valid:                          1'b0,
    r_data:                           '0,
    r_resp:                           `AGC_RESP_OKAY,
    cathode:                          VOLT_1V3,
    anode:                            VOLT_1V3,
    shutdown:                         '0,
    channels:                         `AGC_ALL_CHANNELS,
    integ:                            1'b0,
    single_pair:                      1'b0,
    gap_us:                           `AGC_NO_GAP
  };

  agc_state_type st;
  agc_state_type next_st;

  // word decode, shared by the write and the read path
  function automatic agc_reg_type reg_decode(input logic [`AGC_ADDR_W-1:0] addr);
    logic [`AGC_IDX_W-1:0] idx;
    idx = addr[`AGC_ADDR_W-1:2];
    if (addr[1:0] != 2'b00) begin
      reg_decode = REG_NONE;
    end else if (idx == `AGC_IDX_BIAS) begin
      reg_decode = REG_BIAS;
    end else if (idx == `AGC_IDX_OVR) begin
      reg_decode = REG_OVR;
    end else if (idx == `AGC_IDX_INTEG) begin
      reg_decode = REG_INTEG;
    end else if (idx == `AGC_IDX_OPTS) begin
      reg_decode = REG_OPTS;
    end else begin
      reg_decode = REG_NONE;
    end
  endfunction : reg_decode

  // byte lanes 0 and 1 carry the 16-bit register; lanes 2 and 3 are dropped
  function automatic logic [`AGC_REG_W-1:0] lane_merge(
    input logic [`AGC_REG_W-1:0] old,
    input logic [31:0]           data,
    input logic [3:0]            strb
  );
    lane_merge = old;
    if (strb[0]) begin
      lane_merge[7:0] = data[7:0];
    end
    if (strb[1]) begin
      lane_merge[15:8] = data[15:8];
    end
  endfunction : lane_merge

  // readies carry CE so no AW, W or AR handshake completes while the state is frozen; BVALID and RVALID are not gated
  assign AWREADY = CE && !st.aw_held;
  assign WREADY  = CE && !st.w_held;
  assign ARREADY = CE && !st.r_valid;

  assign BVALID = st.b_valid;
  assign BRESP  = st.b_resp;
  assign RVALID = st.r_valid;
  assign RDATA  = st.r_data;
  assign RRESP  = st.r_resp;

  assign CATHODE_LEVEL              = st.cathode;
  assign ANODE_LEVEL                = st.anode;
  assign FRONT_END_CHANNEL_SHUTDOWN = st.shutdown;
  assign ACTIVE_CHANNELS            = st.channels;
  assign INTEG_ENABLE               = st.integ;
  assign SINGLE_PAIR                = st.single_pair;
  assign GAP_US                     = st.gap_us;

  // phase priority: sleep, then first slot, then second slot
  logic in_sleep;
  logic in_first;
  logic in_second;
  assign in_sleep  = SLEEP_ACTIVE;
  assign in_first  = !SLEEP_ACTIVE && SLOT_A_ACTIVE;
  assign in_second = !SLEEP_ACTIVE && !SLOT_A_ACTIVE && SLOT_B_ACTIVE;

  logic [`AGC_REG_W-1:0] ovr;
  logic [`AGC_REG_W-1:0] opts;
  assign ovr  = st.cathode_override_and_channel_use;
  assign opts = st.integration_sampling_options;

  agc_volt_type sel_cathode;
  agc_volt_type sel_anode;

  agc_bias_select u_bias (
    .override_en (ovr[`AGC_OVR_EN]),
    .global_high (st.afe_bias_and_power[`AGC_GLOBAL_CATH]),
    .in_sleep    (in_sleep),
    .in_first    (in_first),
    .in_second   (in_second),
    .sleep_code  (ovr[`AGC_SLEEP_CATH_HI:`AGC_SLEEP_CATH_LO]),
    .first_code  (ovr[`AGC_A_CATH_HI:`AGC_A_CATH_LO]),
    .second_code (ovr[`AGC_B_CATH_HI:`AGC_B_CATH_LO]),
    .cathode     (sel_cathode),
    .anode       (sel_anode)
  );

  // per-slot settings, index 0 first slot, index 1 second slot
  logic [1:0]       slot_onech;
  logic [1:0]       slot_integ;
  logic [1:0]       slot_pair;
  logic [1:0][4:0]  slot_fine;
  logic [1:0][3:0]  slot_chan;
  logic [1:0][4:0]  slot_gap;
  assign slot_onech = {ovr[`AGC_B_ONECH], ovr[`AGC_A_ONECH]};
  assign slot_integ = {st.slot_integration_enable[`AGC_B_INTEG],
                       st.slot_integration_enable[`AGC_A_INTEG]};
  assign slot_pair  = {opts[`AGC_B_PAIR], opts[`AGC_A_PAIR]};
  assign slot_fine  = {SECOND_SLOT_FINE_OFFSET, FIRST_SLOT_FINE_OFFSET};

  for (genvar s = 0; s < 2; s++) begin : g_slot
    assign slot_chan[s] = slot_onech[s] ? `AGC_ONE_CHANNEL : `AGC_ALL_CHANNELS;
    assign slot_gap[s]  = opts[`AGC_GAP_EN] ? slot_fine[s] : `AGC_NO_GAP;
  end

  always_comb begin
    next_st = st;
    if (AWVALID && AWREADY) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = AWADDR;
    end
    if (WVALID && WREADY) begin
      next_st.w_held = 1'b1;
      next_st.w_data = WDATA;
      next_st.w_strb = WSTRB;
    end
    if (st.b_valid && BREADY) begin
      next_st.b_valid = 1'b0;
    end
    // a new write waits for the previous response to drain
    if (st.aw_held && st.w_held && !st.b_valid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.b_valid = 1'b1;
      next_st.b_resp  = `AGC_RESP_OKAY;
      unique case (reg_decode(st.aw_addr))
        REG_BIAS: begin
          next_st.afe_bias_and_power =
            lane_merge(st.afe_bias_and_power, st.w_data, st.w_strb);
        end
        REG_OVR: begin
          next_st.cathode_override_and_channel_use =
            lane_merge(ovr, st.w_data, st.w_strb);
        end
        REG_INTEG: begin
          next_st.slot_integration_enable =
            lane_merge(st.slot_integration_enable, st.w_data, st.w_strb);
        end
        REG_OPTS: begin
          next_st.integration_sampling_options =
            lane_merge(opts, st.w_data, st.w_strb);
        end
        default: begin
          next_st.b_resp = `AGC_RESP_SLVERR;
        end
      endcase
    end
    if (st.r_valid && RREADY) begin
      next_st.r_valid = 1'b0;
    end
    if (ARVALID && ARREADY) begin
      next_st.r_valid = 1'b1;
      next_st.r_resp  = `AGC_RESP_OKAY;
      unique case (reg_decode(ARADDR))
        REG_BIAS: begin
          next_st.r_data = 32'(st.afe_bias_and_power);
        end
        REG_OVR: begin
          next_st.r_data = 32'(ovr);
        end
        REG_INTEG: begin
          next_st.r_data = 32'(st.slot_integration_enable);
        end
        REG_OPTS: begin
          next_st.r_data = 32'(opts);
        end
        default: begin
          next_st.r_data = '0;
          next_st.r_resp = `AGC_RESP_SLVERR;
        end
      endcase
    end
    next_st.cathode  = sel_cathode;
    next_st.anode    = sel_anode;
    next_st.shutdown = st.afe_bias_and_power[`AGC_SHUT_HI:`AGC_SHUT_LO];
    // outside both slots nothing integrates and all channels are offered
    next_st.channels    = `AGC_ALL_CHANNELS;
    next_st.integ       = 1'b0;
    next_st.single_pair = 1'b0;
    next_st.gap_us      = `AGC_NO_GAP;
    if (in_first) begin
      next_st.channels    = slot_chan[0];
      next_st.integ       = slot_integ[0];
      next_st.single_pair = slot_pair[0];
      next_st.gap_us      = slot_gap[0];
    end else if (in_second) begin
      next_st.channels    = slot_chan[1];
      next_st.integ       = slot_integ[1];
      next_st.single_pair = slot_pair[1];
      next_st.gap_us      = slot_gap[1];
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      st <= RESET_STATE;
    end else if (CE) begin
      st <= next_st;
    end
  end

  // helper terms sampled by the checks below
  logic ce_first;
  logic ce_second;
  logic ce_sleep_ovr;
  logic ce_no_ovr;
  logic write_go;
  logic glob_bit;
  logic gap_bit;
  logic [1:0] a_code;
  logic [1:0] b_code;
  logic [1:0] s_code;
  assign ce_first     = CE && in_first;
  assign ce_second    = CE && in_second;
  assign ce_sleep_ovr = CE && in_sleep && ovr[`AGC_OVR_EN];
  assign ce_no_ovr    = CE && !ovr[`AGC_OVR_EN];
  assign write_go     = CE && st.aw_held && st.w_held && !st.b_valid;
  assign glob_bit     = st.afe_bias_and_power[`AGC_GLOBAL_CATH];
  assign gap_bit      = opts[`AGC_GAP_EN];
  assign a_code       = ovr[`AGC_A_CATH_HI:`AGC_A_CATH_LO];
  assign b_code       = ovr[`AGC_B_CATH_HI:`AGC_B_CATH_LO];
  assign s_code       = ovr[`AGC_SLEEP_CATH_HI:`AGC_SLEEP_CATH_LO];

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  global_cathode_a: assert property (
    ce_no_ovr |=> CATHODE_LEVEL == ($past(glob_bit) ? VOLT_1V8 : VOLT_1V3))
    else $error("global cathode level wrong");

  shutdown_field_a: assert property (
    CE |=> FRONT_END_CHANNEL_SHUTDOWN == $past(st.afe_bias_and_power[`AGC_SHUT_HI:`AGC_SHUT_LO]))
    else $error("channel shutdown field not passed out");

  second_channels_a: assert property (
    ce_second |=> ACTIVE_CHANNELS == ($past(slot_onech[1]) ? 4'h1 : 4'hf))
    else $error("second slot channel use wrong");

  first_channels_a: assert property (
    ce_first |=> ACTIVE_CHANNELS == ($past(slot_onech[0]) ? 4'h1 : 4'hf))
    else $error("first slot channel use wrong");

  sleep_bias_a: assert property (
    ce_sleep_ovr |=> CATHODE_LEVEL == agc_volt_type'($past(s_code))
                     && ANODE_LEVEL == CATHODE_LEVEL)
    else $error("sleep bias wrong");

  second_bias_a: assert property (
    ce_second && ovr[`AGC_OVR_EN] |=> CATHODE_LEVEL == agc_volt_type'($past(b_code))
                                     && ANODE_LEVEL == VOLT_1V3)
    else $error("second slot bias wrong");

  first_bias_a: assert property (
    ce_first && ovr[`AGC_OVR_EN] |=> CATHODE_LEVEL == agc_volt_type'($past(a_code))
                                    && ANODE_LEVEL == VOLT_1V3)
    else $error("first slot bias wrong");

  second_integ_a: assert property (
    ce_second |=> INTEG_ENABLE == $past(slot_integ[1]))
    else $error("second slot integration enable wrong");

  first_integ_a: assert property (
    ce_first |=> INTEG_ENABLE == $past(slot_integ[0]) && SINGLE_PAIR == $past(slot_pair[0]))
    else $error("first slot mode wrong");

  first_gap_a: assert property (
    ce_first |=> GAP_US == ($past(gap_bit) ? $past(FIRST_SLOT_FINE_OFFSET) : `AGC_NO_GAP))
    else $error("integration gap wrong");

  second_pair_a: assert property (
    ce_second |=> SINGLE_PAIR == $past(slot_pair[1]))
    else $error("second slot pair mode wrong");

  write_store_a: assert property (
    write_go && reg_decode(st.aw_addr) == REG_OVR && st.w_strb[1:0] == 2'b11
    |=> BVALID && st.cathode_override_and_channel_use == $past(st.w_data[15:0]))
    else $error("register write not stored whole");

endmodule : agc_config_regs

`default_nettype wire

//--- design/agc_defines.svh
// register offsets, field positions, reset values and bus codes of the front-end config bank
`ifndef AGC_DEFINES_SVH
`define AGC_DEFINES_SVH

`define AGC_ADDR_W         12
`define AGC_IDX_W          10
`define AGC_REG_W          16

// register indices; byte address is four times the index
`define AGC_IDX_BIAS       10'h03c
`define AGC_IDX_OVR        10'h054
`define AGC_IDX_INTEG      10'h058
`define AGC_IDX_OPTS       10'h05a

`define AGC_RST_BIAS       16'h3006
`define AGC_RST_OVR        16'h0020
`define AGC_RST_INTEG      16'h0000
`define AGC_RST_OPTS       16'h0000

// afe_bias_and_power
`define AGC_GLOBAL_CATH    9
`define AGC_SHUT_HI        8
`define AGC_SHUT_LO        3
// cathode_override_and_channel_use
`define AGC_B_ONECH        15
`define AGC_A_ONECH        14
`define AGC_SLEEP_CATH_HI  13
`define AGC_SLEEP_CATH_LO  12
`define AGC_B_CATH_HI      11
`define AGC_B_CATH_LO      10
`define AGC_A_CATH_HI      9
`define AGC_A_CATH_LO      8
`define AGC_OVR_EN         7
// slot_integration_enable
`define AGC_B_INTEG        13
`define AGC_A_INTEG        12
// integration_sampling_options
`define AGC_GAP_EN         7
`define AGC_B_PAIR         6
`define AGC_A_PAIR         5

`define AGC_ALL_CHANNELS   4'hf
`define AGC_ONE_CHANNEL    4'h1
`define AGC_NO_GAP         5'h00

`define AGC_RESP_OKAY      2'b00
`define AGC_RESP_SLVERR    2'b10

`endif

//--- design/agc_pkg.sv
// types shared by the front-end configuration bank
`include "agc_defines.svh"

package agc_pkg;

  // cathode and anode level codes, shared by sleep and both slots
  typedef enum logic [1:0] {
    VOLT_1V8  = 2'b00,
    VOLT_1V3  = 2'b01,
    VOLT_1V55 = 2'b10,
    VOLT_0V0  = 2'b11
  } agc_volt_type;

  typedef enum logic [2:0] {
    REG_BIAS  = 3'b000,
    REG_OVR   = 3'b001,
    REG_INTEG = 3'b010,
    REG_OPTS  = 3'b011,
    REG_NONE  = 3'b100
  } agc_reg_type;

  typedef struct packed {
    logic [`AGC_REG_W-1:0]  afe_bias_and_power;
    logic [`AGC_REG_W-1:0]  cathode_override_and_channel_use;
    logic [`AGC_REG_W-1:0]  slot_integration_enable;
    logic [`AGC_REG_W-1:0]  integration_sampling_options;
    logic                   aw_held;
    logic [`AGC_ADDR_W-1:0] aw_addr;
    logic                   w_held;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   b_valid;
    logic [1:0]             b_resp;
    logic                   r_valid;
    logic [31:0]            r_data;
    logic [1:0]             r_resp;
    agc_volt_type           cathode;
    agc_volt_type           anode;
    logic [5:0]             shutdown;
    logic [3:0]             channels;
    logic                   integ;
    logic                   single_pair;
    logic [4:0]             gap_us;
  } agc_state_type;

endpackage : agc_pkg

//--- design/agc_bias_select.sv
// photodiode cathode and anode level selection
`timescale 1ns/1ps
`default_nettype none

module agc_bias_select (
  input  wire logic                  override_en,
  input  wire logic                  global_high,
  input  wire logic                  in_sleep,
  input  wire logic                  in_first,
  input  wire logic                  in_second,
  input  wire logic [1:0]            sleep_code,
  input  wire logic [1:0]            first_code,
  input  wire logic [1:0]            second_code,
  output var  agc_pkg::agc_volt_type cathode,
  output var  agc_pkg::agc_volt_type anode
);
  import agc_pkg::*;

  always_comb begin
    cathode = global_high ? VOLT_1V8 : VOLT_1V3;
    anode   = VOLT_1V3;
    if (override_en) begin
      if (in_sleep) begin
        cathode = agc_volt_type'(sleep_code);
      end else if (in_first) begin
        cathode = agc_volt_type'(first_code);
      end else if (in_second) begin
        cathode = agc_volt_type'(second_code);
      end
    end
    // anode follows the cathode in sleep so the diode sees no bias
    if (in_sleep) begin
      anode = cathode;
    end
  end

endmodule : agc_bias_select

`default_nettype wire

//--- testbench/test_afe_global_config_regs.sv
// self-checking bench for the front-end global configuration register bank
`timescale 1ns/1ps
`default_nettype none
`include "agc_defines.svh"

module test_afe_global_config_regs;
  import agc_pkg::*;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  resp;
  } tst_rnote_type;

  typedef struct packed {
    logic [14:0] e;
    logic [5:0]  shut;
    logic [2:0]  rdy;
  } tst_pnote_type;

  logic                   REF_CLK;
  logic                   NRST;
  logic                   CE;
  logic                   AWVALID;
  logic                   AWREADY;
  logic [`AGC_ADDR_W-1:0] AWADDR;
  logic                   WVALID;
  logic                   WREADY;
  logic [31:0]            WDATA;
  logic [3:0]             WSTRB;
  logic                   BVALID;
  logic                   BREADY;
  logic [1:0]             BRESP;
  logic                   ARVALID;
  logic                   ARREADY;
  logic [`AGC_ADDR_W-1:0] ARADDR;
  logic                   RVALID;
  logic                   RREADY;
  logic [31:0]            RDATA;
  logic [1:0]             RRESP;
  logic                   SLEEP_ACTIVE;
  logic                   SLOT_A_ACTIVE;
  logic                   SLOT_B_ACTIVE;
  logic [4:0]             FIRST_SLOT_FINE_OFFSET;
  logic [4:0]             SECOND_SLOT_FINE_OFFSET;
  agc_volt_type           CATHODE_LEVEL;
  agc_volt_type           ANODE_LEVEL;
  logic [5:0]             FRONT_END_CHANNEL_SHUTDOWN;
  logic [3:0]             ACTIVE_CHANNELS;
  logic                   INTEG_ENABLE;
  logic                   SINGLE_PAIR;
  logic [4:0]             GAP_US;
  // software view of the four registers, kept by the driver
  logic [15:0]            shadow [4];
  logic [11:0]            reg_addr [4];
  tst_rnote_type          rq [$];
  logic [1:0]             bq [$];
  tst_rnote_type          seen_note;
  // reset values and the bits that are real fields, per register
  logic [15:0]            dflt [4];
  logic [15:0]            field_mask [4];
  tst_pnote_type          pq [$];
  tst_pnote_type          pn;
  logic [14:0]            last_e;
  event                   phase_shown;
  int                     num_errors;
  int                     cmp_count;

  agc_config_regs DUT (
    .REF_CLK(REF_CLK), .NRST(NRST), .CE(CE),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
    .SLEEP_ACTIVE(SLEEP_ACTIVE), .SLOT_A_ACTIVE(SLOT_A_ACTIVE), .SLOT_B_ACTIVE(SLOT_B_ACTIVE),
    .FIRST_SLOT_FINE_OFFSET(FIRST_SLOT_FINE_OFFSET),
    .SECOND_SLOT_FINE_OFFSET(SECOND_SLOT_FINE_OFFSET),
    .CATHODE_LEVEL(CATHODE_LEVEL), .ANODE_LEVEL(ANODE_LEVEL),
    .FRONT_END_CHANNEL_SHUTDOWN(FRONT_END_CHANNEL_SHUTDOWN),
    .ACTIVE_CHANNELS(ACTIVE_CHANNELS), .INTEG_ENABLE(INTEG_ENABLE),
    .SINGLE_PAIR(SINGLE_PAIR), .GAP_US(GAP_US)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  // idx below zero marks a place that must answer with an error
  task automatic axi_write(input logic [11:0] addr, input logic [31:0] data,
                           input logic [3:0] strb, input int idx);
    int n;
    if (idx < 0) begin
      bq.push_back(`AGC_RESP_SLVERR);
    end else begin
      bq.push_back(`AGC_RESP_OKAY);
      if (strb[0]) shadow[idx][7:0] = data[7:0];
      if (strb[1]) shadow[idx][15:8] = data[15:8];
    end
    @(posedge REF_CLK);
    AWADDR  <= addr;
    WDATA   <= data;
    WSTRB   <= strb;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge REF_CLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      if (BVALID && BREADY) break;
    end
    BREADY <= 1'b0;
    if (n == 50) begin
      num_errors++;
      end_of_test();
    end
  endtask : axi_write

  task automatic axi_read(input logic [11:0] addr, input int idx);
    int            n;
    tst_rnote_type note;
    note.data = (idx < 0) ? 32'h0 : {16'h0, shadow[idx]};
    note.resp = (idx < 0) ? `AGC_RESP_SLVERR : `AGC_RESP_OKAY;
    rq.push_back(note);
    @(posedge REF_CLK);
    ARADDR  <= addr;
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge REF_CLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      if (RVALID && RREADY) break;
    end
    RREADY <= 1'b0;
    if (n == 50) begin
      num_errors++;
      end_of_test();
    end
  endtask : axi_read

  // responses are matched against the oldest note at the handshake edge
  always @(posedge REF_CLK) begin
    if (NRST && BVALID && BREADY) begin
      check({30'h0, BRESP}, {30'h0, bq.pop_front()});
    end
    if (NRST && RVALID && RREADY) begin
      seen_note = rq.pop_front();
      check(RDATA, seen_note.data);
      check({30'h0, RRESP}, {30'h0, seen_note.resp});
    end
  end

  // phase notes are taken once the driver marks the outputs as settled
  always @(phase_shown) begin
    pn = pq.pop_front();
    check({30'h0, CATHODE_LEVEL}, {30'h0, pn.e[14:13]});
    check({30'h0, ANODE_LEVEL}, {30'h0, pn.e[12:11]});
    check({26'h0, FRONT_END_CHANNEL_SHUTDOWN}, {26'h0, pn.shut});
    check({28'h0, ACTIVE_CHANNELS}, {28'h0, pn.e[10:7]});
    check({30'h0, INTEG_ENABLE, SINGLE_PAIR}, {30'h0, pn.e[6:5]});
    check({27'h0, GAP_US}, {27'h0, pn.e[4:0]});
    check({29'h0, AWREADY, WREADY, ARREADY}, {29'h0, pn.rdy});
  end

  // expected {cathode, anode, channels, integ, pair, gap}; ph 0 idle, 1 sleep, 2 A, 3 B
  function automatic logic [14:0] model(input logic [1:0] ph, input logic [4:0] fa,
                                        input logic [4:0] fb);
    logic [1:0] cath;
    logic [1:0] an;
    logic [3:0] ch;
    logic [6:0] rest;
    cath = shadow[0][9] ? 2'h0 : 2'h1;
    an   = 2'h1;
    ch   = 4'hf;
    rest = 7'h00;
    case (ph)
      2'd1: begin
        if (shadow[1][7]) cath = shadow[1][13:12];
        an = cath;
      end
      2'd2: begin
        if (shadow[1][7]) cath = shadow[1][9:8];
        ch   = shadow[1][14] ? 4'h1 : 4'hf;
        rest = {shadow[2][12], shadow[3][5], shadow[3][7] ? fa : 5'h00};
      end
      2'd3: begin
        if (shadow[1][7]) cath = shadow[1][11:10];
        ch   = shadow[1][15] ? 4'h1 : 4'hf;
        rest = {shadow[2][13], shadow[3][6], shadow[3][7] ? fb : 5'h00};
      end
      default: ;
    endcase
    return {cath, an, ch, rest};
  endfunction : model

  // reserved bits go out at their defaults, as software is expected to write them
  function automatic logic [31:0] fill_rsvd(input int idx, input logic [31:0] v);
    return {16'h0, (v[15:0] & field_mask[idx]) | (dflt[idx] & ~field_mask[idx])};
  endfunction : fill_rsvd

  // frozen: clock enable held low, so outputs keep what they last showed
  task automatic check_phases(input logic frozen);
    tst_pnote_type note;
    logic [4:0]    fa;
    logic [4:0]    fb;
    for (int ph = 0; ph < 4; ph++) begin
      fa = 5'($urandom);
      fb = 5'($urandom);
      if (!frozen) last_e = model(2'(ph), fa, fb);
      note.e    = last_e;
      note.shut = shadow[0][8:3];
      note.rdy  = frozen ? 3'b000 : 3'b111;
      pq.push_back(note);
      @(posedge REF_CLK);
      CE                      <= !frozen;
      SLEEP_ACTIVE            <= (ph == 1);
      SLOT_A_ACTIVE           <= (ph == 2);
      SLOT_B_ACTIVE           <= (ph == 3);
      FIRST_SLOT_FINE_OFFSET  <= fa;
      SECOND_SLOT_FINE_OFFSET <= fb;
      // outputs follow the phase one edge later
      @(posedge REF_CLK);
      #1;
      -> phase_shown;
    end
    @(posedge REF_CLK);
    CE <= 1'b1;
  endtask : check_phases

  initial begin
    REF_CLK = 1'b0;
    forever #12.5 REF_CLK = ~REF_CLK;
  end

  initial begin
    NRST = 1'b0;
    CE = 1'b1;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    AWADDR = 12'h000;
    ARADDR = 12'h000;
    WDATA = 32'h0;
    WSTRB = 4'h0;
    {SLEEP_ACTIVE, SLOT_A_ACTIVE, SLOT_B_ACTIVE} = 3'h0;
    FIRST_SLOT_FINE_OFFSET = 5'h00;
    SECOND_SLOT_FINE_OFFSET = 5'h00;
    num_errors = 0;
    cmp_count = 0;
    dflt = '{`AGC_RST_BIAS, `AGC_RST_OVR, `AGC_RST_INTEG, `AGC_RST_OPTS};
    field_mask = '{16'h03f8, 16'hff80, 16'h3000, 16'h00e0};
    shadow = dflt;
    last_e = 15'h0;
    reg_addr[0] = {`AGC_IDX_BIAS, 2'b00};
    reg_addr[1] = {`AGC_IDX_OVR, 2'b00};
    reg_addr[2] = {`AGC_IDX_INTEG, 2'b00};
    reg_addr[3] = {`AGC_IDX_OPTS, 2'b00};
    void'($urandom(32'h0073));
    repeat (12) @(posedge REF_CLK);
    NRST <= 1'b1;
    for (int i = 0; i < 4; i++) axi_read(reg_addr[i], i);
    check_phases(1'b0);
    // unmapped and misaligned places refuse and leave the bank untouched
    axi_write(12'h004, 32'hffff_ffff, 4'hf, -1);
    axi_write(reg_addr[1] + 12'h001, 32'h0000_ffff, 4'hf, -1);
    axi_read(12'h004, -1);
    axi_read(reg_addr[3] + 12'h002, -1);
    // channels two to four shut down, reserved defaults kept
    axi_write(reg_addr[0], 32'h0000_31c6, 4'h3, 0);
    axi_read(reg_addr[0], 0);
    check_phases(1'b0);
    // a single byte lane leaves the upper byte alone
    axi_write(reg_addr[1], 32'hdead_bea0, 4'h1, 1);
    axi_read(reg_addr[1], 1);
    // first four rounds sweep every cathode code with override on
    // slot mode and path codes sit outside this bank; software sets them with the enables
    for (int k = 0; k < 24; k++) begin
      for (int i = 0; i < 4; i++) begin
        axi_write(reg_addr[i], fill_rsvd(i, $urandom), 4'($urandom), i);
      end
      if (k < 4) axi_write(reg_addr[1], {16'h0, 2'(k), 2'(k), 2'(k), 2'(k), 8'ha0}, 4'h3, 1);
      for (int i = 0; i < 4; i++) axi_read(reg_addr[i], i);
      check_phases(1'b0);
    end
    // clock enable low: phase changes are ignored and no ready is offered
    check_phases(1'b1);
    for (int i = 0; i < 4; i++) axi_read(reg_addr[i], i);
    end_of_test();
  end

endmodule : test_afe_global_config_regs
`default_nettype wire
